// File: common/serial_pkg.sv
// constants and types shared by the asynchronous serial unit
package serial_pkg;
  localparam int data_width = 8;
  localparam int oversample = 16;
  localparam int half_bit = 8;
  localparam logic [1:0] clk_src_internal = 2'b00;
  localparam logic [1:0] clk_src_int_out = 2'b01;
  localparam logic [1:0] clk_src_external = 2'b10;
  localparam logic [15:0] divisor_reset = 16'h0001;
  localparam logic [3:0] sub_reset = 4'h0;
  localparam logic [3:0] bit_reset = 4'h0;
  localparam logic [data_width-1:0] data_reset = 8'h00;
  typedef enum logic [1:0] {st_idle, st_start, st_data, st_stop} frame_state_t;
endpackage

// File: common/tick_if.sv
// sixteen-times tick shared between clock selector and frame engines
`timescale 1ns/100ps
interface tick_if;
  logic tick;
  logic [3:0] phase;
  modport source (output tick, output phase);
  modport sink (input tick, input phase);
endinterface

// File: core/serial_clock_select.sv
// sixteen-times tick source: internal divider or external pin, plus bit clock output
`timescale 1ns/100ps
module serial_clock_select
  import serial_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration
  input wire logic async_mode,
  input wire logic [1:0] clock_source,
  input wire logic [15:0] baud_divisor,
  // pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  // tick
  tick_if.source tk
);
  typedef struct packed {
    logic [15:0] div_cnt;
    logic [3:0] phase;
    logic tick;
    logic pin_q;
    logic clk_out;
    logic oe_n;
  } sel_state_t;
  sel_state_t s, next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.pin_q = serial_clock_pin_in;
    if (async_mode && clock_source == clk_src_external)
    begin
      next_s.tick = serial_clock_pin_in & ~s.pin_q;
      next_s.div_cnt = divisor_reset;
    end
    else if (s.div_cnt >= baud_divisor)
    begin
      next_s.div_cnt = divisor_reset;
      next_s.tick = 1'b1;
    end
    else
      next_s.div_cnt = s.div_cnt + 16'h0001;
    if (s.tick)
      next_s.phase = s.phase + 4'h1;
    // rising edge at mid bit: low in first half of the bit, high in second
    // taken from the next phase so the fall lines up with the txd change
    next_s.clk_out = (next_s.phase >= 4'(half_bit));
    next_s.oe_n = ~(async_mode && clock_source == clk_src_int_out);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      s <= '{div_cnt: divisor_reset, phase: sub_reset, tick: 1'b0, pin_q: 1'b0,
             clk_out: 1'b0, oe_n: 1'b1};
    else
      s <= next_s;
  end

  assign tk.tick = s.tick;
  assign tk.phase = s.phase;
  assign serial_clock_pin_out = s.clk_out;
  assign serial_clock_pin_oe_n = s.oe_n;
endmodule

// File: core/async_serial_unit.sv
// asynchronous serial unit: independent double-buffered transmitter and receiver
`timescale 1ns/100ps
module async_serial_unit
  import serial_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration
  input wire logic async_mode,
  input wire logic clock_source_bit0,
  input wire logic clock_source_bit1,
  input wire logic [15:0] baud_divisor,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic two_stop,
  // transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_write,
  output logic tx_buffer_empty,
  output logic tx_end,
  // receive side
  output logic [7:0] rx_data,
  output logic rx_full,
  input wire logic rx_read,
  output logic rx_frame_error,
  output logic rx_parity_error,
  output logic rx_overrun,
  // serial pins
  output logic txd,
  input wire logic rxd,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n
);
  typedef struct packed {
    frame_state_t tst;
    logic [3:0] tsub;
    logic [3:0] tbit;
    logic [7:0] tshift;
    logic tpar;
    logic [7:0] tbuf;
    logic tbuf_empty;
    logic tend;
    logic txd;
    frame_state_t rst;
    logic [3:0] rsub;
    logic [3:0] rbit;
    logic [7:0] rshift;
    logic rpar;
    logic rxd_q;
    logic [7:0] rbuf;
    logic rfull;
    logic fer;
    logic per;
    logic oer;
  } unit_state_t;
  unit_state_t s, next_s;
  tick_if tk ();

  serial_clock_select u_clksel (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_mode(async_mode),
    .clock_source({clock_source_bit1, clock_source_bit0}),
    .baud_divisor(baud_divisor),
    .serial_clock_pin_in(serial_clock_pin_in),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .tk(tk.source)
  );

  // index of the last data bit, or of the parity slot when parity is on
  function automatic logic [3:0] last_bit(input logic par);
    last_bit = par ? 4'(data_width) : 4'(data_width - 1);
  endfunction

  always_comb
  begin
    next_s = s;
    // ---- transmitter ----
    if (tx_write)
    begin
      next_s.tbuf = tx_data;
      next_s.tbuf_empty = 1'b0;
    end
    if (tk.tick && (s.tst == st_idle || tk.phase == 4'hf))
    begin
      // frames start on a phase wrap so the output clock lines up with bits
      case (s.tst)
        st_idle, st_stop:
        begin
          if (s.tst == st_stop && two_stop && s.tbit == bit_reset)
          begin
            next_s.tbit = 4'h1;
            next_s.txd = 1'b1;
          end
          else if (!s.tbuf_empty && (s.tst == st_stop || tk.phase == 4'hf))
          begin
            next_s.tst = st_start;
            next_s.tshift = s.tbuf;
            next_s.tpar = parity_odd;
            next_s.tbuf_empty = 1'b1;
            next_s.tend = 1'b0;
            next_s.txd = 1'b0;
          end
          else
          begin
            next_s.tst = st_idle;
            next_s.txd = 1'b1;
            next_s.tend = s.tbuf_empty;
          end
        end
        st_start, st_data:
        begin
          if (s.tst == st_start)
            next_s.tbit = bit_reset;
          else
            next_s.tbit = s.tbit + 4'h1;
          if (s.tst == st_data && s.tbit == last_bit(parity_enable))
          begin
            next_s.tst = st_stop;
            next_s.tbit = bit_reset;
            next_s.txd = 1'b1;
          end
          else
          begin
            next_s.tst = st_data;
            if (next_s.tbit == 4'(data_width))
              next_s.txd = s.tpar;
            else
            begin
              next_s.txd = s.tshift[0];
              next_s.tshift = s.tshift >> 1;
              next_s.tpar = s.tpar ^ s.tshift[0];
            end
          end
        end
        default: next_s.tst = st_idle;
      endcase
    end
    // a fresh write wins over the engine emptying the buffer
    if (tx_write)
    begin
      next_s.tbuf_empty = 1'b0;
      next_s.tend = 1'b0;
    end
    // receiver, runs alongside the transmitter
    if (rx_read)
      next_s.rfull = 1'b0;
    if (tk.tick)
    begin
      next_s.rxd_q = rxd;
      next_s.rsub = s.rsub + 4'h1;
      case (s.rst)
        st_idle:
          if (s.rxd_q && !rxd)
          begin
            next_s.rst = st_start;
            next_s.rsub = sub_reset;
          end
        st_start:
          if (s.rsub == 4'(half_bit - 1))
          begin
            next_s.rst = rxd ? st_idle : st_data;
            next_s.rsub = sub_reset;
            next_s.rbit = bit_reset;
            next_s.rpar = parity_odd;
          end
        st_data:
          if (s.rsub == 4'(oversample - 1))
          begin
            next_s.rsub = sub_reset;
            next_s.rbit = s.rbit + 4'h1;
            next_s.rpar = s.rpar ^ rxd;
            if (s.rbit < 4'(data_width))
              next_s.rshift = {rxd, s.rshift[7:1]};
            if (s.rbit == last_bit(parity_enable))
              next_s.rst = st_stop;
          end
        st_stop:
          if (s.rsub == 4'(oversample - 1))
          begin
            // only the first stop bit is checked; later ones are idle line
            next_s.rst = st_idle;
            next_s.fer = !rxd;
            next_s.per = parity_enable && s.rpar;
            if (s.rfull && !rx_read)
              next_s.oer = 1'b1;
            else
            begin
              next_s.rbuf = s.rshift;
              next_s.rfull = 1'b1;
              next_s.oer = 1'b0;
            end
          end
        default: next_s.rst = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.tst <= st_idle;
      s.rst <= st_idle;
      s.tbuf_empty <= 1'b1;
      s.tend <= 1'b1;
      s.txd <= 1'b1;
      s.rxd_q <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign txd = s.txd;
  assign tx_buffer_empty = s.tbuf_empty;
  assign tx_end = s.tend;
  assign rx_data = s.rbuf;
  assign rx_full = s.rfull;
  assign rx_frame_error = s.fer;
  assign rx_parity_error = s.per;
  assign rx_overrun = s.oer;
endmodule

// File: verif/serial_remote.sv
// remote asynchronous transmitter/receiver facing the serial unit
`timescale 1ns/100ps
module serial_remote (
  // line and clock pin
  input wire logic txd,
  output logic rxd,
  output logic clk_pin
);
  logic ext_run = 1'b0;
  initial rxd = 1'b1;
  // sixteen-times clock, still while not selected
  initial
  begin
    clk_pin = 1'b0;
    forever #15 clk_pin = ext_run & ~clk_pin;
  end
  // prepared frame out lsb first, line back to idle high after
  task automatic send(input logic [11:0] f, input int n, input int bit_ns);
    // step off the system clock edge so the unit never races the line
    #1;
    for (int i = 0; i < n; i++)
    begin
      rxd = f[i];
      #(bit_ns);
    end
    rxd = 1'b1;
  endtask
  // samples mid-bit; ends mid stop so a back-to-back start is not missed
  task automatic recv(input int bit_ns, output logic [11:0] f);
    int k;
    f = 'x;
    for (k = 0; k < 100000 && txd !== 1'b0; k++) #1;
    if (k < 100000)
      for (int i = 0; i < 12; i++)
      begin
        #(i ? bit_ns : bit_ns / 2);
        f[i] = txd;
      end
  endtask
endmodule

// File: verif/async_serial_unit_properties.sv
// port timing properties of the asynchronous serial unit
`timescale 1ns/100ps
module async_serial_unit_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // watched ports
  input wire logic async_mode,
  input wire logic clock_source_bit0,
  input wire logic clock_source_bit1,
  input wire logic tx_write,
  input wire logic tx_buffer_empty,
  input wire logic tx_end,
  input wire logic [7:0] rx_data,
  input wire logic rx_full,
  input wire logic rx_read,
  input wire logic rx_overrun,
  input wire logic txd,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n
);
  wire [2:0] sel = {async_mode, clock_source_bit1, clock_source_bit0};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_oe_sel;
    !serial_clock_pin_oe_n |-> $past(sel) == 3'b101;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("pin driven off source 01");
  property p_oe_on;
    sel == 3'b101 |=> !serial_clock_pin_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bit clock not driven");
  property p_bound;
    !serial_clock_pin_oe_n && $changed(txd) |-> !serial_clock_pin_out;
  endproperty
  a_bound: assert property (p_bound) else $error("bit edge in high half");
  property p_rise;
    !serial_clock_pin_oe_n && $rose(serial_clock_pin_out) |-> $stable(txd) [*7];
  endproperty
  a_rise: assert property (p_rise) else $error("rise not mid-bit");
  property p_end;
    tx_end |=> txd;
  endproperty
  a_end: assert property (p_end) else $error("idle line not high");
  property p_fill;
    tx_write && tx_buffer_empty |=> !tx_buffer_empty;
  endproperty
  a_fill: assert property (p_fill) else $error("write not buffered");
  property p_clear;
    rx_read && rx_full |=> !rx_full;
  endproperty
  a_clear: assert property (p_clear) else $error("read kept full");
  property p_hold;
    rx_full && !rx_read |=> $stable(rx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("unread data lost");
  c_rx: cover property ($rose(rx_full));
  c_ovr: cover property ($rose(rx_overrun));
  c_out: cover property ($fell(serial_clock_pin_oe_n));
endmodule
bind async_serial_unit async_serial_unit_properties u_props (.clk_sys, .reset_n, .async_mode,
  .clock_source_bit0, .clock_source_bit1, .tx_write, .tx_buffer_empty, .tx_end, .rx_data,
  .rx_full, .rx_read, .rx_overrun, .txd, .serial_clock_pin_out, .serial_clock_pin_oe_n);

// File: verif/tb_top.sv
// self-checking bench for the asynchronous serial unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
`define WAIT_FOR(c) begin for (int k = 0; k < 20000 && (c) !== 1'b1; k++) @(posedge clk_sys); \
  if ((c) !== 1'b1) begin num_errors++; final_report(); end end
module tb_top;
  logic clk_sys, reset_n, async_mode, clock_source_bit0, clock_source_bit1, tx_write, rx_read;
  logic parity_enable, parity_odd, two_stop;
  logic [15:0] baud_divisor;
  logic [7:0] tx_data;
  wire [7:0] rx_data;
  wire tx_buffer_empty, tx_end, rx_full, rx_frame_error, rx_parity_error, rx_overrun, txd, rxd;
  wire serial_clock_pin_out, serial_clock_pin_oe_n, remote_clk, serial_clock_pin_in;
  int num_errors = 0;
  int n_compared = 0;
  assign serial_clock_pin_in = serial_clock_pin_oe_n ? remote_clk : serial_clock_pin_out;
  async_serial_unit dut (.clk_sys, .reset_n, .async_mode, .clock_source_bit0,
    .clock_source_bit1, .baud_divisor, .parity_enable, .parity_odd, .two_stop, .tx_data,
    .tx_write, .tx_buffer_empty, .tx_end, .rx_data, .rx_full, .rx_read, .rx_frame_error,
    .rx_parity_error, .rx_overrun, .txd, .rxd, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe_n);
  serial_remote rem (.txd, .rxd, .clk_pin(remote_clk));
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // start low, data lsb first, parity, two stops high
  function automatic logic [11:0] mk(input logic [7:0] d, input logic odd);
    return {2'b11, ^d ^ odd, d, 1'b0};
  endfunction
  task automatic cfg(input logic [2:0] c, input logic [15:0] dv, input logic [2:0] p);
    @(posedge clk_sys);
    {async_mode, clock_source_bit1, clock_source_bit0} <= c;
    baud_divisor <= dv;
    {parity_enable, parity_odd, two_stop} <= p;
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys);
    tx_data <= d;
    tx_write <= 1'b1;
    @(posedge clk_sys);
    tx_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd;
    @(posedge clk_sys);
    rx_read <= 1'b1;
    @(posedge clk_sys);
    rx_read <= 1'b0;
  endtask
  task automatic t_duplex;
    logic [11:0] f1, f2;
    cfg(3'b101, 16'h0001, 3'b101);
    fork
      begin
        wr(8'ha5);
        `WAIT_FOR(tx_buffer_empty)
        wr(8'h3c);
      end
      begin
        rem.recv(80, f1);
        rem.recv(80, f2);
      end
      rem.send(mk(8'h96, 1'b0), 12, 80);
    join
    `CHK("tx frame a", mk(8'ha5, 1'b0), f1)
    `CHK("tx frame b", mk(8'h3c, 1'b0), f2)
    `WAIT_FOR(rx_full)
    `CHK("rx data", 8'h96, rx_data)
    `CHK("rx flags", 3'b000, {rx_frame_error, rx_parity_error, rx_overrun})
    `CHK("pin enable", 1'b0, serial_clock_pin_oe_n)
    rd();
    $display("duplex test done");
  endtask
  task automatic t_ext;
    cfg(3'b110, 16'h0001, 3'b000);
    rem.ext_run = 1'b1;
    rem.send({3'b111, 8'h5a, 1'b0}, 11, 480);
    `WAIT_FOR(rx_full)
    `CHK("ext rx data", 8'h5a, rx_data)
    `CHK("ext pin enable", 1'b1, serial_clock_pin_oe_n)
    rem.send({3'b111, 8'hc3, 1'b0}, 11, 480);
    `CHK("overrun", 1'b1, rx_overrun)
    `CHK("kept data", 8'h5a, rx_data)
    rd();
    rem.ext_run = 1'b0;
    $display("external clock test done");
  endtask
  task automatic t_err;
    logic [11:0] f;
    cfg(3'b100, 16'h0002, 3'b110);
    fork
      begin
        wr(8'h81);
        `CHK("tx busy", 1'b0, tx_end)
      end
      rem.recv(160, f);
      rem.send(mk(8'h81, 1'b1) ^ 12'h200, 11, 160);
    join
    `CHK("odd tx frame", mk(8'h81, 1'b1), f)
    `CHK("tx idle", 1'b1, tx_end)
    `CHK("pin released", 1'b1, serial_clock_pin_oe_n)
    `WAIT_FOR(rx_full)
    `CHK("parity flag", 2'b01, {rx_frame_error, rx_parity_error})
    rd();
    rem.send(mk(8'h81, 1'b1) & 12'hbff, 11, 160);
    `WAIT_FOR(rx_full)
    `CHK("frame flag", 1'b1, rx_frame_error)
    $display("error test done");
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    reset_n = 1'b0;
    {clock_source_bit0, clock_source_bit1, parity_enable, parity_odd, two_stop} = '0;
    {tx_write, rx_read, tx_data} = '0;
    async_mode = 1'b1;
    baud_divisor = 16'h0001;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_duplex();
    t_ext();
    t_err();
    final_report();
  end
endmodule
